// *** design/rtscnd_octet.sv ***
`default_nettype none
`include "rtscnd_params.svh"
module rtscnd_octet
  import rtscnd_pkg::*;
(
  input  wire logic [7:0] octet_in,   // line octet, bit 1 is msb
  input  wire logic [7:0] ctrl,       // control word of this slot
  input  wire logic [7:0] user_code,  // user code of this slot
  input  wire logic [1:0] de_src,     // receive d/e source field
  input  wire logic       sig_frame,  // signaling frame
  input  wire logic       sig_bit,    // signaling bit of this octet
  output logic      [7:0] octet_out,  // conditioned octet
  output logic      [1:0] link_sel    // link controller index 0..3
);
  logic [1:0] zs;
  logic [1:0] de;
  logic [3:0] cond;
  logic [7:0] zs_out;
  assign de   = ctrl[`RTSCND_DE_POS+1:`RTSCND_DE_POS];
  assign zs   = ctrl[`RTSCND_ZS_POS+1:`RTSCND_ZS_POS];
  assign cond = ctrl[`RTSCND_COND_POS+3:`RTSCND_COND_POS];
  always_comb begin
    case (de)
      2'h0:    link_sel = 2'h0;
      2'h1:    link_sel = 2'h1;
      2'h3:    link_sel = 2'h2;
      default: link_sel = de_src;
    endcase
  end
  // stuffing modes 1 and 2 force a one only when the octet is all zeros; mode 3 always sends the dds code
  always_comb begin
    zs_out = octet_in;
    case (zs)
      2'h1: begin
        if (octet_in == 8'h00) zs_out = `RTSCND_BIT7_MASK;
      end
      2'h2: begin
        if (octet_in == 8'h00) begin
          if (!sig_frame) zs_out = `RTSCND_BIT8_MASK;
          else if (!sig_bit) zs_out = `RTSCND_BIT7_MASK;
        end
      end
      2'h3: zs_out = `RTSCND_DDS_CODE;
      default: zs_out = octet_in;
    endcase
  end
  always_comb begin
    case (cond)
      RTSCND_C_INV:    octet_out = zs_out ^ `RTSCND_XOR_ALL;
      RTSCND_C_EVEN:   octet_out = zs_out ^ `RTSCND_XOR_EVEN;
      RTSCND_C_ODD:    octet_out = zs_out ^ `RTSCND_XOR_ODD;
      RTSCND_C_USER:   octet_out = user_code;
      RTSCND_C_BUSY:   octet_out = `RTSCND_BUSY_CODE;
      RTSCND_C_VACANT: octet_out = `RTSCND_VACANT_CODE;
      RTSCND_C_OOF:    octet_out = `RTSCND_OOF_CODE;
      RTSCND_C_MSB:    octet_out = zs_out ^ `RTSCND_MSB_MASK;
      default:         octet_out = zs_out;
    endcase
  end
endmodule
`default_nettype wire

// *** design/rtscnd_params.svh ***
`ifndef RTSCND_PARAMS_SVH
`define RTSCND_PARAMS_SVH
`define RTSCND_NUM_SLOTS      24
// register indices count 32-bit words, so each word sits at four times its index
`define RTSCND_CTRL_IDX       12'h360
`define RTSCND_USER_IDX       12'h380
`define RTSCND_DESRC_IDX      12'h10c
`define RTSCND_STAT_IDX       12'h3fc
`define RTSCND_CTRL_BASE      12'hd80
`define RTSCND_USER_BASE      12'he00
`define RTSCND_DESRC_ADDR     12'h430
`define RTSCND_STAT_ADDR      12'hff0
`define RTSCND_CTRL_RESET     8'h80
`define RTSCND_USER_RESET     8'hff
`define RTSCND_DESRC_RESET    2'h0
`define RTSCND_DE_POS         6
`define RTSCND_ZS_POS         4
`define RTSCND_COND_POS       0
`define RTSCND_DESRC_POS      0
`define RTSCND_DDS_CODE       8'h98
`define RTSCND_BUSY_CODE      8'h7f
`define RTSCND_VACANT_CODE    8'hff
`define RTSCND_OOF_CODE       8'h1a
`define RTSCND_XOR_ALL        8'hff
`define RTSCND_XOR_EVEN       8'haa
`define RTSCND_XOR_ODD        8'h55
`define RTSCND_MSB_MASK       8'h80
`define RTSCND_LSB_MASK       8'h7f
`define RTSCND_BIT7_MASK      8'h02
`define RTSCND_BIT8_MASK      8'h01
`endif

// *** design/rtscnd_pkg.sv ***
`default_nettype none
package rtscnd_pkg;
  typedef enum logic [1:0] {
    RTSCND_AX_IDLE = 2'h0,
    RTSCND_AX_RESP = 2'h1
  } rtscnd_ax_type;
  typedef enum logic [3:0] {
    RTSCND_C_PASS   = 4'h0,
    RTSCND_C_INV    = 4'h1,
    RTSCND_C_EVEN   = 4'h2,
    RTSCND_C_ODD    = 4'h3,
    RTSCND_C_USER   = 4'h4,
    RTSCND_C_BUSY   = 4'h5,
    RTSCND_C_VACANT = 4'h6,
    RTSCND_C_OOF    = 4'h8,
    RTSCND_C_MSB    = 4'hb,
    RTSCND_C_PASS2  = 4'he
  } rtscnd_cond_type;
  typedef struct packed {
    logic [7:0] octet;
    logic [1:0] link_sel;
    logic       valid;
    logic [4:0] slot;
  } rtscnd_out_type;
endpackage
`default_nettype wire

// *** design/rtscnd_top.sv ***
`default_nettype none
`include "rtscnd_params.svh"
module rtscnd_top
  import rtscnd_pkg::*;
(
  input  wire logic        aclk,        // 125 mhz clock
  input  wire logic        aresetn,     // synchronous reset, active low
  input  wire logic [11:0] s_awaddr,    // write address
  input  wire logic [2:0]  s_awprot,    // unused protection
  input  wire logic        s_awvalid,   // write address valid
  output logic             s_awready,   // write address ready
  input  wire logic [31:0] s_wdata,     // write data
  input  wire logic [3:0]  s_wstrb,     // byte enables
  input  wire logic        s_wvalid,    // write data valid
  output logic             s_wready,    // write data ready
  output logic      [1:0]  s_bresp,     // write response
  output logic             s_bvalid,    // write response valid
  input  wire logic        s_bready,    // write response ready
  input  wire logic [11:0] s_araddr,    // read address
  input  wire logic [2:0]  s_arprot,    // unused protection
  input  wire logic        s_arvalid,   // read address valid
  output logic             s_arready,   // read address ready
  output logic      [31:0] s_rdata,     // read data
  output logic      [1:0]  s_rresp,     // read response
  output logic             s_rvalid,    // read data valid
  input  wire logic        s_rready,    // read data ready
  input  wire logic        rx_valid,    // line octet strobe
  input  wire logic [4:0]  rx_slot,     // timeslot of line octet
  input  wire logic [7:0]  rx_octet,    // line octet
  input  wire logic        rx_sig_frame, // signaling frame flag
  input  wire logic        rx_sig_bit,  // signaling bit of octet
  output logic             bp_valid,    // backplane octet strobe
  output logic      [4:0]  bp_slot,     // backplane timeslot
  output logic      [7:0]  bp_octet,    // conditioned octet
  output logic      [1:0]  bp_link_sel, // link controller index when d/e
  output logic      [7:0]  bp_count     // octets passed, wraps
);
  typedef struct packed {
    logic [`RTSCND_NUM_SLOTS-1:0][7:0] ctrl;
    logic [`RTSCND_NUM_SLOTS-1:0][7:0] user;
    logic [1:0]    de_src;
    rtscnd_ax_type wst;
    logic          aw_got;
    logic          w_got;
    logic [11:0]   awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    rtscnd_out_type out;
    logic [7:0]    count;
  } rtscnd_state_type;
  rtscnd_state_type state_r;
  rtscnd_state_type state_nxt;
  logic [7:0] cond_octet;
  logic [1:0] cond_link;
  logic       slot_ok;
  logic [4:0] slot_idx;
  logic [4:0] w_idx;
  logic [4:0] r_idx;
  logic       w_ctrl;
  logic       w_user;
  logic       w_de;
  logic       w_stat;
  logic       r_ctrl;
  logic       r_user;
  assign slot_ok  = rx_slot < 5'(`RTSCND_NUM_SLOTS);
  assign slot_idx = slot_ok ? rx_slot : 5'h00;
  // control word is sampled when the octet arrives, so a write lands at a boundary
  rtscnd_octet u_octet (
    .octet_in  (rx_octet),
    .ctrl      (state_r.ctrl[slot_idx]),
    .user_code (state_r.user[slot_idx]),
    .de_src    (state_r.de_src),
    .sig_frame (rx_sig_frame),
    .sig_bit   (rx_sig_bit),
    .octet_out (cond_octet),
    .link_sel  (cond_link)
  );
  function automatic logic [4:0] word_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    word_idx = d[6:2];
  endfunction
  function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
    in_bank = (a >= base) && (a < base + 12'(4 * `RTSCND_NUM_SLOTS)) && (a[1:0] == 2'h0);
  endfunction
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    merge = s[0] ? d[7:0] : old;
  endfunction
  always_comb begin
    w_idx  = word_idx(state_r.awaddr, `RTSCND_CTRL_BASE);
    w_ctrl = in_bank(state_r.awaddr, `RTSCND_CTRL_BASE);
    w_user = in_bank(state_r.awaddr, `RTSCND_USER_BASE);
    w_de   = state_r.awaddr == `RTSCND_DESRC_ADDR;
    w_stat = state_r.awaddr == `RTSCND_STAT_ADDR;
    r_idx  = word_idx(s_araddr, `RTSCND_CTRL_BASE);
    r_ctrl = in_bank(s_araddr, `RTSCND_CTRL_BASE);
    r_user = in_bank(s_araddr, `RTSCND_USER_BASE);
  end
  always_comb begin
    state_nxt = state_r;
    if (s_awvalid && !state_r.aw_got && state_r.wst == RTSCND_AX_IDLE) begin
      state_nxt.aw_got = 1'b1;
      state_nxt.awaddr = s_awaddr;
    end
    if (s_wvalid && !state_r.w_got && state_r.wst == RTSCND_AX_IDLE) begin
      state_nxt.w_got = 1'b1;
      state_nxt.wdata = s_wdata;
      state_nxt.wstrb = s_wstrb;
    end
    case (state_r.wst)
      RTSCND_AX_IDLE: begin
        if (state_r.aw_got && state_r.w_got) begin
          state_nxt.bresp = 2'h2;
          if (w_ctrl) begin
            state_nxt.ctrl[w_idx] = merge(state_r.ctrl[w_idx], state_r.wdata, state_r.wstrb);
            state_nxt.bresp = 2'h0;
          end else if (w_user) begin
            state_nxt.user[word_idx(state_r.awaddr, `RTSCND_USER_BASE)] =
              merge(state_r.user[word_idx(state_r.awaddr, `RTSCND_USER_BASE)],
                    state_r.wdata, state_r.wstrb);
            state_nxt.bresp = 2'h0;
          end else if (w_de) begin
            if (state_r.wstrb[0]) state_nxt.de_src = state_r.wdata[1:0];
            state_nxt.bresp = 2'h0;
          end else if (w_stat) begin
            state_nxt.bresp = 2'h0;
          end
          state_nxt.aw_got = 1'b0;
          state_nxt.w_got  = 1'b0;
          state_nxt.bvalid = 1'b1;
          state_nxt.wst    = RTSCND_AX_RESP;
        end
      end
      RTSCND_AX_RESP: begin
        if (s_bready) begin
          state_nxt.bvalid = 1'b0;
          state_nxt.wst    = RTSCND_AX_IDLE;
        end
      end
      default: state_nxt.wst = RTSCND_AX_IDLE;
    endcase
    if (state_r.rvalid) begin
      if (s_rready) state_nxt.rvalid = 1'b0;
    end else if (s_arvalid) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp  = 2'h0;
      state_nxt.rdata  = 32'h0000_0000;
      if (r_ctrl) state_nxt.rdata[7:0] = state_r.ctrl[r_idx];
      else if (r_user) state_nxt.rdata[7:0] = state_r.user[word_idx(s_araddr, `RTSCND_USER_BASE)];
      else if (s_araddr == `RTSCND_DESRC_ADDR) state_nxt.rdata[1:0] = state_r.de_src;
      else if (s_araddr == `RTSCND_STAT_ADDR) state_nxt.rdata[7:0] = state_r.count;
      else state_nxt.rresp = 2'h2;
    end
    state_nxt.out.valid = rx_valid && slot_ok;
    if (rx_valid && slot_ok) begin
      state_nxt.out.octet    = cond_octet;
      state_nxt.out.link_sel = cond_link;
      state_nxt.out.slot     = rx_slot;
      state_nxt.count        = state_r.count + 8'h01;
    end
    if (!aresetn) begin
      state_nxt        = '0;
      state_nxt.ctrl   = {`RTSCND_NUM_SLOTS{`RTSCND_CTRL_RESET}};
      state_nxt.user   = {`RTSCND_NUM_SLOTS{`RTSCND_USER_RESET}};
      state_nxt.de_src = `RTSCND_DESRC_RESET;
      state_nxt.wst    = RTSCND_AX_IDLE;
    end
  end
  always_ff @(posedge aclk) begin
    state_r <= state_nxt;
  end
  assign s_awready   = !state_r.aw_got && state_r.wst == RTSCND_AX_IDLE;
  assign s_wready    = !state_r.w_got && state_r.wst == RTSCND_AX_IDLE;
  assign s_bvalid    = state_r.bvalid;
  assign s_bresp     = state_r.bresp;
  assign s_arready   = !state_r.rvalid;
  assign s_rvalid    = state_r.rvalid;
  assign s_rdata     = state_r.rdata;
  assign s_rresp     = state_r.rresp;
  assign bp_valid    = state_r.out.valid;
  assign bp_slot     = state_r.out.slot;
  assign bp_octet    = state_r.out.octet;
  assign bp_link_sel = state_r.out.link_sel;
  assign bp_count    = state_r.count;

  logic [7:0] past_octet;
  logic [7:0] past_ctrl;
  logic [7:0] past_user;
  always_ff @(posedge aclk) begin
    past_octet <= rx_octet;
    past_ctrl  <= state_r.ctrl[slot_idx];
    past_user  <= state_r.user[slot_idx];
  end
  out_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_valid && slot_ok |=> bp_valid && bp_slot == $past(rx_slot))
    else $error("backplane octet missing");
  bad_slot_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_valid && !slot_ok |=> !bp_valid)
    else $error("out of range slot passed");
  inv_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bp_valid && $past(aresetn) && past_ctrl == 8'h01 |-> bp_octet == (past_octet ^ 8'hff))
    else $error("inversion wrong");
  even_inv_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bp_valid && $past(aresetn) && past_ctrl == 8'h02 |-> bp_octet == (past_octet ^ 8'haa))
    else $error("even inversion wrong");
  user_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bp_valid && $past(aresetn) && past_ctrl[3:0] == 4'h4 |-> bp_octet == past_user)
    else $error("user code wrong");
  busy_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bp_valid && $past(aresetn) && past_ctrl[3:0] == 4'h5 |-> bp_octet == 8'h7f)
    else $error("busy code wrong");
  oof_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bp_valid && $past(aresetn) && past_ctrl[3:0] == 4'h8 |-> bp_octet == 8'h1a)
    else $error("out of frame code wrong");
  dds_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bp_valid && $past(aresetn) && past_ctrl == 8'h30 |-> bp_octet == 8'h98)
    else $error("dds code wrong");
  pass_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bp_valid && $past(aresetn) && past_ctrl == 8'h0e |-> bp_octet == past_octet)
    else $error("pass code altered octet");
  link_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bp_valid && $past(aresetn) && past_ctrl[7:6] == 2'h3 |-> bp_link_sel == 2'h2)
    else $error("link select wrong");
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_bvalid && !s_bready |=> s_bvalid)
    else $error("write response dropped");
  wr_cov: cover property (@(posedge aclk) disable iff (!aresetn) s_bvalid && s_bready);
  rd_cov: cover property (@(posedge aclk) disable iff (!aresetn) s_rvalid && s_rready);
  user_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    bp_valid && past_ctrl[3:0] == 4'h4);
endmodule
`default_nettype wire

// *** tb/rtscnd_bp_model.sv ***
`default_nettype none
module rtscnd_bp_model (
  input  wire logic       aclk,       // system clock
  input  wire logic       aresetn,    // sync reset, active low
  input  wire logic       bp_valid,   // octet strobe from the framer
  input  wire logic [4:0] bp_slot,    // timeslot of the octet
  output logic      [7:0] rcv_count   // octets taken, wraps
);
  timeunit 1ns;
  timeprecision 1ps;
  // the backplane only listens: it has no way to stall the framer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rcv_count <= 8'h00;
    end else if (bp_valid && bp_slot < 5'd24) begin
      rcv_count <= rcv_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, bp_link_sel;
  logic rx_valid = 1'b0, rx_sig_frame = 1'b0, rx_sig_bit = 1'b0, bp_valid;
  logic [4:0] rx_slot = 5'h00, bp_slot;
  logic [7:0] rx_octet = 8'h00, bp_octet, bp_count, rcv_count, sent = 8'h00;
  logic [31:0] rd;
  logic [1:0] rs;
  int bad_count = 0, checks = 0, cyc = 0;

  always #4 aclk = ~aclk;

  rtscnd_top rtscnd_top_inst (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awprot(3'h0), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arprot(3'h0),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .rx_valid(rx_valid), .rx_slot(rx_slot),
    .rx_octet(rx_octet), .rx_sig_frame(rx_sig_frame), .rx_sig_bit(rx_sig_bit),
    .bp_valid(bp_valid), .bp_slot(bp_slot), .bp_octet(bp_octet),
    .bp_link_sel(bp_link_sel), .bp_count(bp_count));

  rtscnd_bp_model rtscnd_bp_model_inst (.aclk(aclk), .aresetn(aresetn),
    .bp_valid(bp_valid), .bp_slot(bp_slot), .rcv_count(rcv_count));

  task automatic final_report();
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    // far more than the whole sequence needs
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask

  task automatic send(input logic [4:0] sl, input logic [7:0] o, input logic sf, input logic sb);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_slot <= sl;
    rx_octet <= o;
    rx_sig_frame <= sf;
    rx_sig_bit <= sb;
    @(posedge aclk);
    rx_valid <= 1'b0;
    #1;
    if (sl < 5'd24) sent = sent + 8'h01;
  endtask

  task automatic t_reset();
    axr(12'hd80, rd, rs);
    chk({rs, rd}, {2'h0, 32'h80}, "ctrl reset");
    axr(12'he00, rd, rs);
    chk({rs, rd}, {2'h0, 32'hff}, "user reset");
    axr(12'h430, rd, rs);
    chk({rs, rd}, {2'h0, 32'h0}, "desrc reset");
    axr(12'h200, rd, rs);
    chk({rs, rd}, {2'h2, 32'h0}, "unmapped read");
    axw(12'h204, 32'h12, rs);
    chk({30'h0, rs}, 32'h2, "unmapped write");
  endtask

  // every code is written just before its octet, so a late update would show
  task automatic t_codes();
    logic [7:0] e;
    axw(12'he14, 32'h5a, rs);
    for (int c = 0; c < 16; c++) begin
      axw(12'hd94, c, rs);
      case (c)
        1: e = 8'hc3;
        2: e = 8'h96;
        3: e = 8'h69;
        4: e = 8'h5a;
        5: e = 8'h7f;
        6: e = 8'hff;
        8: e = 8'h1a;
        11: e = 8'hbc;
        default: e = 8'h3c;
      endcase
      send(5'd5, 8'h3c, 1'b0, 1'b0);
      chk({bp_valid, bp_slot, bp_octet}, {1'b1, 5'd5, e}, "cond code");
    end
  endtask

  task automatic t_zero();
    logic [1:0] zs [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3};
    logic       sf [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic       sb [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [7:0] e  [6] = '{8'h00, 8'h02, 8'h01, 8'h02, 8'h00, 8'h98};
    for (int i = 0; i < 6; i++) begin
      axw(12'hd9c, {26'h0, zs[i], 4'h0}, rs);
      send(5'd7, 8'h00, sf[i], sb[i]);
      chk(bp_octet, e[i], "zero suppress");
    end
  endtask

  task automatic t_link();
    logic [1:0] e [5] = '{2'd0, 2'd1, 2'd2, 2'd2, 2'd1};
    axw(12'h430, 32'h2, rs);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) axw(12'h430, 32'h1, rs);
      axw(12'hd84, (i == 4) ? 32'h80 : (i << 6), rs);
      send(5'd1, 8'h11, 1'b0, 1'b0);
      chk({bp_link_sel, bp_octet}, {e[i], 8'h11}, "link select");
    end
  endtask

  task automatic t_slots();
    axw(12'hddc, 32'h1, rs);
    send(5'd23, 8'h0f, 1'b0, 1'b0);
    chk({bp_valid, bp_slot, bp_octet}, {1'b1, 5'd23, 8'hf0}, "last slot");
    send(5'd0, 8'h0f, 1'b0, 1'b0);
    chk({bp_valid, bp_slot, bp_octet}, {1'b1, 5'd0, 8'h0f}, "first slot");
    send(5'd24, 8'h0f, 1'b0, 1'b0);
    chk({31'h0, bp_valid}, 32'h0, "slot out of range");
    axr(12'hff0, rd, rs);
    chk(rd, {24'h0, sent}, "status count");
    chk({24'h0, rcv_count}, {24'h0, sent}, "backplane count");
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_codes();
    t_zero();
    t_link();
    t_slots();
    final_report();
  end
endmodule
`default_nettype wire
